// ===== rtl/cth_history.sv
`timescale 1ns/100ps
`default_nettype none
module cth_history
  import cth_pkg::*;
#(
  parameter int DEPTH = HIST_DEPTH,
  parameter int DW = 5
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic push,
  input wire logic [DW-1:0] push_data,
  input wire logic pop,
  input wire logic ovf_clr,
  output logic [DW-1:0] get_data,
  output logic [DW-1:0] last_data,
  output logic empty,
  output logic overflow
);
  localparam int PW = $clog2(DEPTH);
  logic [DW-1:0] mem [DEPTH];
  logic [PW-1:0] wr_r, rd_r, wr_nxt, rd_nxt;
  logic empty_r, ovf_r, full;

  // Pointer steps wrap at the list size, not at a power of two.
  function automatic logic [PW-1:0] inc(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1; // R24
  endfunction
  function automatic logic [PW-1:0] dec(input logic [PW-1:0] p);
    return (p == '0) ? PW'(DEPTH - 1) : p - 1'b1;
  endfunction

  // Full when the write pointer sits one behind the read pointer.
  always_comb begin
    full = (wr_r == dec(rd_r));
    rd_nxt = (pop && !empty_r) ? inc(rd_r) : rd_r; // R17
    wr_nxt = (push && !full) ? inc(wr_r) : wr_r; // R16
  end

  // Entries carry no reset, so contents after init are undefined.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[full ? dec(wr_r) : wr_r] <= push_data; // R13 R14 R20
    end
  end

  // Pointers return to the start while the module is in init mode.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_r <= '0;
      rd_r <= '0;
    end else if (clear) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
    end
  end

  // A pending overflow keeps empty set, so software must clear it first.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      empty_r <= 1'b1;
    end else if (clear) begin
      empty_r <= 1'b1;
    end else if (push && !ovf_r && (rd_nxt != wr_nxt)) begin
      empty_r <= 1'b0; // R18 R22
    end else if (pop && (rd_nxt == wr_nxt)) begin
      empty_r <= 1'b1; // R18
    end
  end

  // The set beats a software clear arriving in the same cycle.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ovf_r <= 1'b0;
    end else if (clear) begin
      ovf_r <= 1'b0;
    end else if (push && !full && (inc(wr_r) == dec(rd_nxt))) begin
      ovf_r <= 1'b1; // R19 R21
    end else if (ovf_clr) begin
      ovf_r <= 1'b0; // R22
    end
  end

  assign get_data = mem[rd_r];
  assign last_data = mem[dec(wr_r)]; // R15
  assign empty = empty_r;
  assign overflow = ovf_r;

  a_ptr_wrap: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_r < PW'(DEPTH)) && (rd_r < PW'(DEPTH))) // R24
    else $error("history pointer beyond list size");
  a_ovf_sticky: assert property (@(posedge clk) disable iff (!reset_n)
    ovf_r && !ovf_clr && !clear |=> ovf_r) // R22
    else $error("overflow flag dropped without clear");
  a_empty_held: assert property (@(posedge clk) disable iff (!reset_n)
    empty_r && ovf_r && !clear |=> empty_r) // R22
    else $error("empty flag cleared while overflow pending");
  a_empty_ptrs: assert property (@(posedge clk) disable iff (!reset_n)
    !empty_r |-> (rd_r != wr_r)) // R18
    else $error("list not empty but pointers match");
  a_last_out: assert property (@(posedge clk) disable iff (!reset_n)
    push && !clear |=> last_data == $past(push_data)) // R15
    else $error("last-out entry does not match recorded number");
  a_ovf_on_fill: assert property (@(posedge clk) disable iff (!reset_n)
    !clear && push && !pop && !full && (inc(wr_r) == dec(rd_r))
    |=> ovf_r && full) // R19
    else $error("overflow not flagged when list filled");
endmodule
`default_nettype wire

// ===== rtl/cth_pkg.sv
// Summary of operation
// R01 - Only buffers with request, in use, type 000 and ready join the search.
// R02 - Lowest identifier bits 28..18 wins; standard ties beat extended frames.
// R03 - Standard data frames beat standard remote frames and extended frames.
// R04 - Standard frames beat extended frames on the third criterion.
// R05 - Equal base and RTR extended frames: lowest lower 18 bits wins.
// R06 - Identical identifiers: lowest buffer number transmits first.
// R07 - A frame already being sent is never pre-empted by a newer request.
// R08 - Block send mode keeps one request among buffers 0..7, arbitrated normally.
// R09 - Successful transmission clears the sending buffer's request bit.
// R10 - Completion status is set only if the buffer interrupt enable is set.
// R11 - Done interrupt needs both module and buffer interrupt enables.
// R12 - Ready flag may stay locked during transfer; software reads it back.
// R13 - Every transmitted frame's buffer number goes into a seven-entry list.
// R14 - History contents are undefined after leaving initialization mode.
// R15 - Last-out register returns the entry at write pointer minus one.
// R16 - Each record writes at the write pointer then increments it.
// R17 - Reading the get register returns oldest entry and bumps read pointer.
// R18 - Empty flag set when pointers equal, cleared when a record separates them.
// R19 - Overflow flag set when write pointer reaches read pointer minus one.
// R20 - While full, a new completion overwrites the newest entry.
// R21 - Six completions fit without reads before overflow is reached.
// R22 - Overflow stays until software clears it and blocks clearing of empty.
// R23 - Frames from block send area buffers are not recorded in history.
// R24 - History pointers wrap modulo seven.
package cth_pkg;
  localparam int ADDR_W = 12;
  localparam int BUF_SH = 4;
  localparam int WORD_SH = 2;
  localparam logic [ADDR_W-1:0] A_MODE = 12'h000;
  localparam logic [ADDR_W-1:0] A_IRQ_EN = 12'h004;
  localparam logic [ADDR_W-1:0] A_INT_STAT = 12'h008;
  localparam logic [ADDR_W-1:0] A_LAST_OUT = 12'h00c;
  localparam logic [ADDR_W-1:0] A_HIST_GET = 12'h010;
  localparam logic [ADDR_W-1:0] A_TX_STAT = 12'h014;
  localparam logic [ADDR_W-1:0] A_BUF_BASE = 12'h200;
  localparam logic [1:0] BO_CFG = 2'h0;
  localparam logic [1:0] BO_CTL = 2'h1;
  localparam logic [1:0] BO_ID = 2'h2;
  localparam int MODE_INIT = 0;
  localparam int MODE_ABT = 1;
  localparam int MODE_TRIG = 2;
  localparam int CFG_USE = 0;
  localparam int CFG_TYPE_LO = 1;
  localparam int CFG_TYPE_HI = 3;
  localparam int CFG_RTR = 4;
  localparam int CFG_IDE = 5;
  localparam int CTL_TRQ = 0;
  localparam int CTL_RDY = 1;
  localparam int CTL_IE = 2;
  localparam int HIST_NUM_LO = 0;
  localparam int HIST_EMPTY = 8;
  localparam int HIST_OVF = 9;
  localparam int STAT_BUSY = 0;
  localparam int STAT_CUR_LO = 8;
  localparam int ID_W = 29;
  localparam int ID_BASE_LO = 18;
  localparam int ID_EXT_W = 18;
  localparam int KEY_W = 32;
  localparam logic [2:0] TYPE_TX = 3'h0;
  localparam int HIST_DEPTH = 7;
  localparam int ABT_BUFS = 8;
  localparam logic [2:0] ABT_LAST = 3'h7;
  typedef enum logic {CTH_IDLE, CTH_SEND} cth_state_t;
endpackage

// ===== rtl/cth_tx_arbiter.sv
// The address map and the APB register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module cth_tx_arbiter
  import cth_pkg::*;
#(
  parameter int NUM_BUF = 32
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic tx_req,
  output logic [$clog2(NUM_BUF)-1:0] tx_buf,
  output logic [ID_W-1:0] tx_id,
  output logic tx_ide,
  output logic tx_rtr,
  input wire logic tx_ok,
  input wire logic tx_err,
  output logic tx_done_irq
);
  localparam int BW = $clog2(NUM_BUF);

  // Per-buffer configuration and control storage.
  logic [NUM_BUF-1:0] in_use_r, rtr_r, ide_r, trq_r, rdy_r, ie_r;
  logic [2:0] type_r [NUM_BUF];
  logic [ID_W-1:0] id_r [NUM_BUF];
  logic init_r, abt_mode_r, trig_r, tx_irq_en_r, tx_done_status_r;
  logic [2:0] abt_ptr_r;
  cth_state_t state_r;
  logic [BW-1:0] tx_cur_r;
  logic tx_req_r, tx_ide_r, tx_rtr_r, tx_done_irq_r;
  logic [ID_W-1:0] tx_id_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r;

  // Bus decode signals.
  logic setup, acc, wr_acc, buf_hit, reg_err;
  logic [ADDR_W-1:0] boff;
  logic [BW-1:0] bidx;
  logic [1:0] bsel;
  logic [31:0] rd_val;
  logic sw_ctl_wr, hist_pop, hist_ovf_clr;

  // Arbitration and sequencing signals.
  logic [NUM_BUF-1:0] elig;
  logic found;
  logic [BW-1:0] best_idx;
  logic [KEY_W-1:0] best_key, cand_key;
  logic done_ok, cur_in_abt, abt_active, abt_set, abt_stop, lock_on;
  logic [BW-1:0] lock_idx;
  logic [BW-1:0] hist_get, hist_last;
  logic hist_empty, hist_ovf;

  // Rank key, lowest wins: base id, then standard data frame, then
  // standard before extended, then extended bits, then RTR.
  function automatic logic [KEY_W-1:0] prio_key(
    input logic [ID_W-1:0] id,
    input logic id_extension_bit,
    input logic rtr
  );
    return {id[ID_W-1:ID_BASE_LO], // R02
            id_extension_bit | rtr, // R03
            id_extension_bit, // R04
            id_extension_bit ? id[ID_EXT_W-1:0] : {ID_EXT_W{1'b0}}, // R05
            rtr};
  endfunction

  // Strict less-than on an ascending scan keeps the lowest buffer on ties.
  always_comb begin
    found = 1'b0;
    best_idx = '0;
    best_key = '1;
    cand_key = '0;
    for (int i = 0; i < NUM_BUF; i++) begin
      elig[i] = trq_r[i] && in_use_r[i] && (type_r[i] == TYPE_TX)
                && rdy_r[i]; // R01
      cand_key = prio_key(id_r[i], ide_r[i], rtr_r[i]);
      if (elig[i] && (!found || (cand_key < best_key))) begin // R06
        found = 1'b1;
        best_idx = BW'(i);
        best_key = cand_key;
      end
    end
  end

  // APB address decode and read multiplexer.
  always_comb begin
    setup = psel && !penable;
    acc = psel && penable && pready_r;
    wr_acc = acc && pwrite && !pslverr_r;
    boff = paddr - A_BUF_BASE;
    buf_hit = (paddr >= A_BUF_BASE) && (int'(boff >> BUF_SH) < NUM_BUF);
    bidx = boff[BW+BUF_SH-1:BUF_SH];
    bsel = boff[BUF_SH-1:WORD_SH];
    rd_val = '0;
    reg_err = 1'b0;
    if (paddr == A_MODE) begin
      rd_val[MODE_INIT] = init_r;
      rd_val[MODE_ABT] = abt_mode_r;
      rd_val[MODE_TRIG] = trig_r;
    end else if (paddr == A_IRQ_EN) begin
      rd_val[0] = tx_irq_en_r;
    end else if (paddr == A_INT_STAT) begin
      rd_val[0] = tx_done_status_r;
    end else if (paddr == A_LAST_OUT) begin
      rd_val[HIST_NUM_LO +: BW] = hist_last; // R15
    end else if (paddr == A_HIST_GET) begin
      rd_val[HIST_NUM_LO +: BW] = hist_get; // R17
      rd_val[HIST_EMPTY] = hist_empty;
      rd_val[HIST_OVF] = hist_ovf;
    end else if (paddr == A_TX_STAT) begin
      rd_val[STAT_BUSY] = (state_r == CTH_SEND);
      rd_val[STAT_CUR_LO +: BW] = tx_cur_r;
    end else if (buf_hit && (bsel == BO_CFG)) begin
      rd_val[CFG_USE] = in_use_r[bidx];
      rd_val[CFG_TYPE_HI:CFG_TYPE_LO] = type_r[bidx];
      rd_val[CFG_RTR] = rtr_r[bidx];
      rd_val[CFG_IDE] = ide_r[bidx];
    end else if (buf_hit && (bsel == BO_CTL)) begin
      rd_val[CTL_TRQ] = trq_r[bidx];
      rd_val[CTL_RDY] = rdy_r[bidx];
      rd_val[CTL_IE] = ie_r[bidx];
    end else if (buf_hit && (bsel == BO_ID)) begin
      rd_val[ID_W-1:0] = id_r[bidx];
    end else begin
      reg_err = 1'b1;
    end
    sw_ctl_wr = wr_acc && buf_hit && (bsel == BO_CTL);
    // Reading an already empty list must not advance the read pointer.
    hist_pop = acc && !pwrite && !pslverr_r && (paddr == A_HIST_GET)
               && !prdata_r[HIST_EMPTY]; // R17
    hist_ovf_clr = wr_acc && (paddr == A_HIST_GET) && pwdata[HIST_OVF];
  end

  // No transfer takes a wait state; ready is raised in the first access cycle and data is captured in setup.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      pready_r <= setup;
      if (setup) begin
        pslverr_r <= reg_err;
        prdata_r <= pwrite ? '0 : rd_val;
      end
    end
  end

  // Global mode and interrupt enable registers.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      init_r <= 1'b1;
      abt_mode_r <= 1'b0;
      tx_irq_en_r <= 1'b0;
    end else if (wr_acc && (paddr == A_MODE)) begin
      init_r <= pwdata[MODE_INIT];
      abt_mode_r <= pwdata[MODE_ABT];
    end else if (wr_acc && (paddr == A_IRQ_EN)) begin
      tx_irq_en_r <= pwdata[0];
    end
  end

  // Status is write-one-to-clear; a completion in the same cycle wins.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_done_status_r <= 1'b0;
    end else if (done_ok && ie_r[tx_cur_r]) begin
      tx_done_status_r <= 1'b1; // R10
    end else if (wr_acc && (paddr == A_INT_STAT) && pwdata[0]) begin
      tx_done_status_r <= 1'b0;
    end
  end

  // Buffer configuration and identifiers are plain software storage.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      in_use_r <= '0;
      rtr_r <= '0;
      ide_r <= '0;
      for (int i = 0; i < NUM_BUF; i++) begin
        type_r[i] <= TYPE_TX;
        id_r[i] <= '0;
      end
    end else if (wr_acc && buf_hit && (bsel == BO_CFG)) begin
      in_use_r[bidx] <= pwdata[CFG_USE];
      type_r[bidx] <= pwdata[CFG_TYPE_HI:CFG_TYPE_LO];
      rtr_r[bidx] <= pwdata[CFG_RTR];
      ide_r[bidx] <= pwdata[CFG_IDE];
    end else if (wr_acc && buf_hit && (bsel == BO_ID)) begin
      id_r[bidx] <= pwdata[ID_W-1:0];
    end
  end

  // The buffer about to be or being sent holds its ready flag; software
  // must read ready back after clearing it.
  always_comb begin
    lock_on = (state_r == CTH_SEND) || (found && !init_r);
    lock_idx = (state_r == CTH_SEND) ? tx_cur_r : best_idx;
  end

  // Request and ready bits: hardware acts first, a software write last.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      trq_r <= '0;
      rdy_r <= '0;
      ie_r <= '0;
    end else begin
      if (done_ok) begin
        trq_r[tx_cur_r] <= 1'b0; // R09
      end
      if (abt_set) begin
        trq_r[abt_ptr_r] <= 1'b1; // R08
      end
      if (sw_ctl_wr) begin
        trq_r[bidx] <= pwdata[CTL_TRQ] | (abt_set && (abt_ptr_r == bidx));
        rdy_r[bidx] <= pwdata[CTL_RDY]
                       | (lock_on && (lock_idx == bidx)); // R12
        ie_r[bidx] <= pwdata[CTL_IE];
      end
    end
  end

  // Block send walks buffers 0..7 holding one request at a time; a
  // buffer that is not ready stops the walk where it stands.
  always_comb begin
    done_ok = (state_r == CTH_SEND) && tx_ok;
    cur_in_abt = int'(tx_cur_r) < ABT_BUFS;
    abt_active = abt_mode_r && trig_r && !init_r;
    abt_set = abt_active && (trq_r[ABT_BUFS-1:0] == '0) && rdy_r[abt_ptr_r]
              && !done_ok; // R08
    abt_stop = abt_active && (trq_r[ABT_BUFS-1:0] == '0)
               && !rdy_r[abt_ptr_r];
  end

  // Trigger: hardware clears at the end of the block or on a stop.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      trig_r <= 1'b0;
      abt_ptr_r <= '0;
    end else begin
      if (done_ok && abt_mode_r && cur_in_abt) begin
        abt_ptr_r <= abt_ptr_r + 1'b1;
        if (abt_ptr_r == ABT_LAST) begin
          trig_r <= 1'b0;
        end
      end
      if (abt_stop) begin
        trig_r <= 1'b0;
      end
      if (wr_acc && (paddr == A_MODE)) begin
        trig_r <= pwdata[MODE_TRIG];
      end
    end
  end

  // Once offered to the link a frame stays until the link reports its
  // end, so a newer higher request waits for the next search.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= CTH_IDLE;
      tx_req_r <= 1'b0;
      tx_cur_r <= '0;
      tx_id_r <= '0;
      tx_ide_r <= 1'b0;
      tx_rtr_r <= 1'b0;
    end else begin
      case (state_r)
        CTH_IDLE: begin
          if (found && !init_r) begin
            state_r <= CTH_SEND;
            tx_req_r <= 1'b1;
            tx_cur_r <= best_idx;
            tx_id_r <= id_r[best_idx];
            tx_ide_r <= ide_r[best_idx];
            tx_rtr_r <= rtr_r[best_idx];
          end
        end
        CTH_SEND: begin
          if (tx_ok || tx_err) begin // R07
            state_r <= CTH_IDLE;
            tx_req_r <= 1'b0;
          end
        end
        default: state_r <= CTH_IDLE;
      endcase
    end
  end

  // One-cycle done request, gated by both enables.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_done_irq_r <= 1'b0;
    end else begin
      tx_done_irq_r <= done_ok && tx_irq_en_r && ie_r[tx_cur_r]; // R11
    end
  end

  // Block send area frames are kept out of the history in that mode.
  cth_history #(
    .DEPTH(HIST_DEPTH),
    .DW(BW)
  ) u_hist (
    .clk(clk),
    .reset_n(reset_n),
    .clear(init_r),
    .push(done_ok && !(abt_mode_r && cur_in_abt)), // R13 R23
    .push_data(tx_cur_r),
    .pop(hist_pop),
    .ovf_clr(hist_ovf_clr),
    .get_data(hist_get),
    .last_data(hist_last),
    .empty(hist_empty),
    .overflow(hist_ovf)
  );

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign tx_req = tx_req_r;
  assign tx_buf = tx_cur_r;
  assign tx_id = tx_id_r;
  assign tx_ide = tx_ide_r;
  assign tx_rtr = tx_rtr_r;
  assign tx_done_irq = tx_done_irq_r;

  a_req_eligible: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(tx_req_r) |-> $past(elig[best_idx]) && $past(found)) // R01
    else $error("frame offered from an ineligible buffer");
  a_req_held: assert property (@(posedge clk) disable iff (!reset_n)
    tx_req_r && !tx_ok && !tx_err |=> tx_req_r && $stable(tx_cur_r)) // R07
    else $error("offered frame changed before the link finished");
  a_trq_cleared: assert property (@(posedge clk) disable iff (!reset_n)
    done_ok && !sw_ctl_wr |=> !trq_r[$past(tx_cur_r)]) // R09
    else $error("request bit not cleared after transmission");
  a_status_set: assert property (@(posedge clk) disable iff (!reset_n)
    done_ok && ie_r[tx_cur_r] |=> tx_done_status_r) // R10
    else $error("completion status not set");
  a_irq_cause: assert property (@(posedge clk) disable iff (!reset_n)
    tx_done_irq_r |-> $past(done_ok) && $past(tx_irq_en_r)) // R11
    else $error("done interrupt without enabled completion");
  a_ready_lock: assert property (@(posedge clk) disable iff (!reset_n)
    tx_req_r |-> rdy_r[tx_cur_r]) // R12
    else $error("ready of sending buffer dropped");
  a_abt_single: assert property (@(posedge clk) disable iff (!reset_n)
    abt_set && !sw_ctl_wr |=> $countones(trq_r[ABT_BUFS-1:0]) == 1) // R08
    else $error("block send holds other than one request");
  a_best_lowest: assert property (@(posedge clk) disable iff (!reset_n)
    found |-> !(elig[0] && (best_idx != '0)
      && (prio_key(id_r[0], ide_r[0], rtr_r[0]) <= best_key))) // R06
    else $error("buffer 0 tie lost to a higher buffer");
endmodule
`default_nettype wire

// ===== testbench/cth_link_model.sv
`timescale 1ns/100ps
`default_nettype none
module cth_link_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic tx_req,
  input wire logic [7:0] delay,
  input wire logic fail,
  output logic tx_ok,
  output logic tx_err
);
  logic [7:0] cnt_r;

  // One end pulse per offered frame after a settable frame time; while
  // fail is set the frame ends in error, so the retry path gets exercised.
  // Nothing is answered while no frame is offered.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 8'h00;
      tx_ok <= 1'b0;
      tx_err <= 1'b0;
    end else begin
      tx_ok <= 1'b0;
      tx_err <= 1'b0;
      if (tx_req && !tx_ok && !tx_err) begin
        if (cnt_r == delay) begin
          cnt_r <= 8'h00;
          tx_ok <= !fail;
          tx_err <= fail;
        end else begin
          cnt_r <= cnt_r + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== testbench/cth_tx_arbiter_tb.sv
`timescale 1ns/100ps
`default_nettype none
module cth_tx_arbiter_tb;
  import cth_pkg::*;
  typedef struct {
    int a;
    int b;
    logic [28:0] ida;
    logic [28:0] idb;
    logic [5:0] cfa;
    logic [5:0] cfb;
    int two;
  } cth_row_t;
  // Two buffers per row, both eligible where two is 1; buffer b must reach the bus first.
  cth_row_t rows[9] = '{
    '{3, 5, 29'h4000000, 29'h3fc0000, 6'h01, 6'h01, 1},
    '{2, 6, 29'h4000000, 29'h4000000, 6'h21, 6'h01, 1},
    '{1, 4, 29'h4000000, 29'h4000000, 6'h11, 6'h01, 1},
    '{3, 8, 29'h4000000, 29'h4000000, 6'h21, 6'h11, 1},
    '{2, 7, 29'h4000005, 29'h4000003, 6'h21, 6'h21, 1},
    '{9, 4, 29'h4000000, 29'h4000000, 6'h01, 6'h01, 1},
    '{12, 13, 29'h4000000, 29'h3fc0005, 6'h01, 6'h21, 1},
    '{20, 22, 29'h0, 29'h4000000, 6'h03, 6'h01, 0},
    '{21, 23, 29'h0, 29'h4000000, 6'h00, 6'h01, 0}
  };
  logic [31:0] hist[6] = '{32'h20a, 32'h20b, 32'h20c, 32'h20d, 32'h20e,
                           32'h210};
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic tx_req, tx_ok, tx_err, tx_done_irq, tx_ide, tx_rtr, fail;
  logic [28:0] tx_id;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] tx_buf;
  logic [7:0] delay;
  logic [4:0] sent[$];
  logic [30:0] hdr[$];
  int n_errors, tests_run, irqs, cycles, k, n, errs;

  cth_tx_arbiter #(.NUM_BUF(32)) DUT (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_req(tx_req),
    .tx_buf(tx_buf), .tx_id(tx_id), .tx_ide(tx_ide), .tx_rtr(tx_rtr),
    .tx_ok(tx_ok), .tx_err(tx_err), .tx_done_irq(tx_done_irq)
  );
  cth_link_model link (
    .clk(clk), .reset_n(reset_n), .tx_req(tx_req), .delay(delay),
    .fail(fail), .tx_ok(tx_ok), .tx_err(tx_err)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Logs every frame the bus accepted and counts interrupt pulses.
  // The cycle ceiling is more than ten times the expected run length.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (tx_ok === 1'b1 && tx_req === 1'b1) begin
      sent.push_back(tx_buf);
      hdr.push_back({tx_ide, tx_rtr, tx_id});
    end
    if (tx_err === 1'b1 && tx_req === 1'b1) errs <= errs + 1;
    if (tx_done_irq === 1'b1) irqs <= irqs + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("Comparisons: %0d, mismatches: %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One transfer; an idle cycle follows so psel never toggles twice.
  task automatic apb(input logic wr_en, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask

  function automatic logic [ADDR_W-1:0] ba(input int m, input int o);
    return A_BUF_BASE + ADDR_W'(16 * m + 4 * o);
  endfunction

  // Ready is dropped and read back first, since it may be held locked.
  task automatic cfg(input int m, input logic [5:0] cf,
                     input logic [28:0] id, input logic [31:0] ctl);
    wr(ba(m, 1), 32'h0);
    rchk(ba(m, 1), 32'h2, 32'h0);
    wr(ba(m, 0), {26'h0, cf});
    wr(ba(m, 2), {3'h0, id});
    wr(ba(m, 1), ctl);
  endtask

  task automatic wait_sent(input int c);
    while (sent.size() < c) @(posedge clk);
  endtask

  task automatic xmit(input int m, input logic [5:0] cf,
                      input logic [31:0] ctl);
    k = sent.size();
    cfg(m, cf, 29'h0, ctl);
    wait_sent(k + 1);
  endtask

  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    delay = 8'h03;
    n_errors = 0;
    tests_run = 0;
    irqs = 0;
    errs = 0;
    fail = 1'b0;
    cycles = 0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    // Reset state and an access to a hole in the buffer map.
    rchk(A_MODE, 32'hffffffff, 32'h1);
    rchk(ba(0, 0), 32'hffffffff, 32'h0);
    apb(1'b0, ba(0, 3), 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(A_IRQ_EN, 32'h1);
    // Both buffers are loaded in init mode so they compete together.
    foreach (rows[i]) begin
      k = sent.size();
      wr(A_MODE, 32'h1);
      cfg(rows[i].a, rows[i].cfa, rows[i].ida, 32'h7);
      cfg(rows[i].b, rows[i].cfb, rows[i].idb, 32'h7);
      wr(A_MODE, 32'h0);
      wait_sent(k + 1 + rows[i].two);
      chk(32'(sent[k]), 32'(rows[i].b));
      chk(32'(hdr[k]), {1'b0, rows[i].cfb[5:4], rows[i].idb});
      if (rows[i].two == 1) chk(32'(sent[k + 1]), 32'(rows[i].a));
      rchk(ba(rows[i].b, 1), 32'h7, 32'h6);
    end
    chk(32'(irqs), 32'(sent.size()));
    rchk(A_INT_STAT, 32'h1, 32'h1);
    // Each enable alone: status needs the buffer enable, the pulse both.
    wr(A_IRQ_EN, 32'h0);
    wr(A_INT_STAT, 32'h1);
    n = irqs;
    xmit(25, 6'h01, 32'h7);
    rchk(A_INT_STAT, 32'h1, 32'h1);
    wr(A_INT_STAT, 32'h1);
    wr(A_IRQ_EN, 32'h1);
    xmit(26, 6'h01, 32'h3);
    rchk(A_INT_STAT, 32'h1, 32'h0);
    chk(32'(irqs), 32'(n));
    // A slow frame in flight is not displaced by a better newcomer.
    delay <= 8'h28;
    k = sent.size();
    cfg(30, 6'h01, 29'h1ffc0000, 32'h7);
    do @(posedge clk); while (tx_req !== 1'b1);
    // Clearing ready of the frame on the bus must not take effect.
    wr(ba(30, 1), 32'h5);
    rchk(ba(30, 1), 32'h2, 32'h2);
    cfg(29, 6'h01, 29'h0, 32'h7);
    wait_sent(k + 2);
    chk(32'(sent[k]), 32'h1e);
    chk(32'(sent[k + 1]), 32'h1d);
    delay <= 8'h03;
    // A failed frame keeps its request, sets no status and is sent again.
    fail <= 1'b1;
    wr(A_INT_STAT, 32'h1);
    k = sent.size();
    cfg(27, 6'h01, 29'h0, 32'h7);
    while (errs == 0) @(posedge clk);
    fail <= 1'b0;
    rchk(A_INT_STAT, 32'h1, 32'h0);
    wait_sent(k + 1);
    chk(32'(sent[k]), 32'h1b);
    // Fill the history past its limit, drain it, then wrap the pointers.
    wr(A_MODE, 32'h1);
    wr(A_MODE, 32'h0);
    rchk(A_HIST_GET, 32'h300, 32'h100);
    for (int m = 10; m < 17; m++) begin
      xmit(m, 6'h01, 32'h7);
      rchk(A_LAST_OUT, 32'h1f, 32'(m));
    end
    foreach (hist[i]) rchk(A_HIST_GET, 32'h31f, hist[i]);
    rchk(A_HIST_GET, 32'h300, 32'h300);
    xmit(18, 6'h01, 32'h7);
    rchk(A_HIST_GET, 32'h300, 32'h300);
    wr(A_HIST_GET, 32'h200);
    xmit(17, 6'h01, 32'h7);
    rchk(A_LAST_OUT, 32'h1f, 32'h11);
    rchk(A_HIST_GET, 32'h31f, 32'h012);
    rchk(A_HIST_GET, 32'h31f, 32'h011);
    // Block send walks buffers 0 to 7 in order and leaves no history.
    cfg(0, 6'h01, 29'h0, 32'h6);
    k = sent.size();
    wr(A_MODE, 32'h2);
    wr(A_MODE, 32'h6);
    wait_sent(k + 8);
    for (int i = 0; i < 8; i++) chk(32'(sent[k + i]), 32'(i));
    rchk(A_MODE, 32'h7, 32'h2);
    rchk(A_HIST_GET, 32'h100, 32'h100);
    // A second reset in mid-run returns the block to init mode.
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rchk(A_MODE, 32'h7, 32'h1);
    rchk(A_HIST_GET, 32'h300, 32'h100);
    print_verdict();
  end
endmodule
`default_nettype wire
